// [rtl/acc_pkg.sv]
// Purpose: Shared constants and types for the converter mode and
//          calibration control block
// Assumes: APB word registers, one core clock
// Notes:   The three-level strap arrives as two comparator bits

package acc_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [5:0] CFG_IDX   = 6'h01;
	localparam logic [5:0] FSADJ_IDX = 6'h03;
	localparam logic [5:0] STAT_IDX  = 6'h04;
	localparam logic [5:0] ISTAT_IDX = 6'h05;
	localparam logic [5:0] IMASK_IDX = 6'h06;

	// Field positions
	localparam int CFG_SYNC_SEL_BIT = 14;
	localparam int ST_EXT_BIT       = 0;
	localparam int ST_CAL_BIT       = 1;
	localparam int ST_RANGE_BIT     = 2;
	localparam int ST_DLY_BIT       = 3;
	localparam int ST_PH_LSB        = 8;

	// Reset values and range codes
	localparam logic [15:0] CFG_RST      = 16'h0000;
	localparam logic [15:0] FSADJ_RST    = 16'h0080;
	localparam logic [7:0]  FS_CODE_LOW  = 8'h00;
	localparam logic [7:0]  FS_CODE_HIGH = 8'hff;

	// Strap comparator codes; any other code means floating or mid
	localparam logic [1:0] STRAP_LOW  = 2'h0;
	localparam logic [1:0] STRAP_HIGH = 2'h3;

	// Interrupt bits
	localparam int INT_W        = 4;
	localparam int INT_CAL_DONE = 0;
	localparam int INT_SYNC     = 1;
	localparam int INT_FRAME    = 2;
	localparam int INT_MODE     = 3;

	// Timing counts in core clock cycles
	localparam int          CNT_W         = 24;
	localparam int          REQ_W         = 7;
	localparam logic [6:0]  CAL_REQ_MIN   = 7'h50;
	localparam int          CAL_SHORT_CYC = 1024;
	localparam int          CAL_LONG_CYC  = 1048576;
	localparam int          CAL_RUN_CYC   = 4096;
	localparam int          PH_W          = 8;

	// Serial frame: four address bits then sixteen data bits
	localparam int         SER_BITS = 20;
	localparam logic [4:0] SER_FULL = 5'h14;

	typedef enum logic [1:0] {
		CAL_WAIT = 2'h1,
		CAL_RUN  = 2'h3,
		CAL_IDLE = 2'h2
	} acc_cal_t;

	typedef struct packed {
		logic [1:0]          strap_m;
		logic [1:0]          strap_s;
		logic                shr_m;
		logic                shr_s;
		logic                sclk_m;
		logic                sclk_s;
		logic                sclk_q;
		logic                sdi_m;
		logic                sdi_s;
		logic                req_m;
		logic                req_s;
		logic                req_q;
		logic                sck_m;
		logic                sck_s;
		logic                sck_q;
		logic                rp_m;
		logic                rp_s;
		logic                rn_m;
		logic                rn_s;
		logic                rs_m;
		logic                rs_s;
		logic                sync_q;
		logic                ext;
		logic [7:0]          fs_code;
		logic [15:0]         cfg;
		logic [15:0]         fsadj;
		logic [SER_BITS-1:0] shreg;
		logic [4:0]          bitcnt;
		logic [INT_W-1:0]    istat;
		logic [INT_W-1:0]    imask;
		acc_cal_t            cal;
		logic [CNT_W-1:0]    cal_cnt;
		logic [REQ_W-1:0]    req_cnt;
		logic                req_low_ok;
		logic [7:0]          sd_m;
		logic [7:0]          sd_s;
		logic [7:0]          sample;
		logic                samp_stb;
		logic [PH_W-1:0]     phase;
	} acc_state_t;

endpackage : acc_pkg

// [rtl/acc_ctrl.sv]
// Purpose: Strap mode decode, range select, calibration sequencing,
//          sample clock sync and serial control for the converter
// Assumes: All converter pins are asynchronous and pass two flops first
// Notes:   One packed state record, one next-state process
// Function
// - Normal mode, strap low: small range
// - Normal mode, strap high: large range
// - Floating strap enables serial and registers
// - Defined strap: shared pin sets calibration delay
// - Floating strap: shared pin is chip select
// - Extended mode: range from adjust register
// - Sample on both sample clock edges
// - Positive sync pulse resets sample clock
// - Config bit 14 set: differential sync
// - Calibration flag high only while running
// - 80 low then 80 high starts calibration
// - Config bit 14 clear: single sync
// - Extended mode: serial clock shifts data
//
// Added by the designer: register access over APB and the register offsets.

`timescale 1ns/1ps

module acc_ctrl #(
	parameter int CAL_SHORT = acc_pkg::CAL_SHORT_CYC,
	parameter int CAL_LONG  = acc_pkg::CAL_LONG_CYC,
	parameter int CAL_RUNC  = acc_pkg::CAL_RUN_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  range_or_ext_ctrl_strap,
	input  wire logic        cal_start_delay_select,
	input  wire logic        serial_clk,
	input  wire logic        serial_input_line,
	input  wire logic        cal_request,
	input  wire logic        sample_clk,
	input  wire logic [7:0]  sample_in,
	input  wire logic        sample_clock_sync_pos,
	input  wire logic        sample_clock_sync_neg,
	input  wire logic        sample_clock_sync_single,
	output logic             ext_ctrl_mode,
	output logic [7:0]       full_scale_code,
	output logic             serial_chip_select_n,
	output logic             cal_delay_long,
	output logic             calibration_active,
	output logic [7:0]       sample_out,
	output logic             sample_valid,
	output logic [7:0]       sample_phase,
	output logic             irq
);

	acc_pkg::acc_state_t st_ff;
	acc_pkg::acc_state_t nxt_st;

	logic                      acc_en;
	logic                      wr_en;
	logic [5:0]                idx;
	logic                      hit;
	logic                      strap_def;
	logic                      cs_n;
	logic                      dly_long;
	logic [acc_pkg::CNT_W-1:0] wait_len;
	logic                      sync_lvl;
	logic                      sync_rise;
	logic                      trig;
	logic [acc_pkg::INT_W-1:0] ev;
	logic [acc_pkg::INT_W-1:0] clr;

	// APB decode; zero wait states, unmapped words answer with an error
	assign acc_en  = psel & penable;
	assign idx     = paddr[7:2];
	assign hit     = (idx == acc_pkg::CFG_IDX) ||
	                 (idx == acc_pkg::FSADJ_IDX) ||
	                 (idx == acc_pkg::STAT_IDX) ||
	                 (idx == acc_pkg::ISTAT_IDX) ||
	                 (idx == acc_pkg::IMASK_IDX);
	assign wr_en   = acc_en & pwrite & hit & ce;
	assign pready  = 1'b1;
	assign pslverr = acc_en & ~hit;

	// Read mux over registered state only
	always_comb begin
		prdata = 32'h0000_0000;
		case (idx)
			acc_pkg::CFG_IDX:   prdata[15:0] = st_ff.cfg;
			acc_pkg::FSADJ_IDX: prdata[15:0] = st_ff.fsadj;
			acc_pkg::STAT_IDX: begin
				prdata[acc_pkg::ST_EXT_BIT]   = st_ff.ext;
				prdata[acc_pkg::ST_CAL_BIT]   = calibration_active;
				prdata[acc_pkg::ST_RANGE_BIT] = st_ff.fs_code[7];
				prdata[acc_pkg::ST_DLY_BIT]   = dly_long;
				prdata[acc_pkg::ST_PH_LSB +: acc_pkg::PH_W] = st_ff.phase;
			end
			acc_pkg::ISTAT_IDX: prdata[acc_pkg::INT_W-1:0] = st_ff.istat;
			acc_pkg::IMASK_IDX: prdata[acc_pkg::INT_W-1:0] = st_ff.imask;
			default:            prdata = 32'h0000_0000;
		endcase
	end

	// Shared pin meaning follows the registered mode flag
	assign strap_def = (st_ff.strap_s == acc_pkg::STRAP_LOW) ||
	                   (st_ff.strap_s == acc_pkg::STRAP_HIGH);
	assign cs_n      = st_ff.ext ? st_ff.shr_s : 1'b1;
	assign dly_long  = st_ff.ext ? 1'b0 : st_ff.shr_s;
	assign wait_len  = dly_long ? acc_pkg::CNT_W'(CAL_LONG - 1)
	                            : acc_pkg::CNT_W'(CAL_SHORT - 1);

	// Sync source picked by config bit; positive differential is P>N
	assign sync_lvl  = st_ff.cfg[acc_pkg::CFG_SYNC_SEL_BIT]
	                 ? (st_ff.rp_s & ~st_ff.rn_s)
	                 : st_ff.rs_s;
	assign sync_rise = sync_lvl & ~st_ff.sync_q;

	// Request qualifies once it has been high long enough after a low
	assign trig = st_ff.req_s & st_ff.req_low_ok &
	              (st_ff.req_cnt == acc_pkg::REQ_W'(acc_pkg::CAL_REQ_MIN - 2));

	// Interrupt clears from APB
	assign clr = (wr_en && idx == acc_pkg::ISTAT_IDX)
	           ? pwdata[acc_pkg::INT_W-1:0] : '0;

	// Next-state logic for the whole block
	always_comb begin
		nxt_st = st_ff;
		ev     = '0;
		// Two-flop synchronisers; first stage read only by the second
		nxt_st.strap_m = range_or_ext_ctrl_strap;
		nxt_st.strap_s = st_ff.strap_m;
		nxt_st.shr_m   = cal_start_delay_select;
		nxt_st.shr_s   = st_ff.shr_m;
		nxt_st.sclk_m  = serial_clk;
		nxt_st.sclk_s  = st_ff.sclk_m;
		nxt_st.sclk_q  = st_ff.sclk_s;
		nxt_st.sdi_m   = serial_input_line;
		nxt_st.sdi_s   = st_ff.sdi_m;
		nxt_st.req_m   = cal_request;
		nxt_st.req_s   = st_ff.req_m;
		nxt_st.req_q   = st_ff.req_s;
		nxt_st.sck_m   = sample_clk;
		nxt_st.sck_s   = st_ff.sck_m;
		nxt_st.sck_q   = st_ff.sck_s;
		nxt_st.rp_m    = sample_clock_sync_pos;
		nxt_st.rp_s    = st_ff.rp_m;
		nxt_st.rn_m    = sample_clock_sync_neg;
		nxt_st.rn_s    = st_ff.rn_m;
		nxt_st.rs_m    = sample_clock_sync_single;
		nxt_st.rs_s    = st_ff.rs_m;
		// Data bus settles long before the synced edge that takes it
		nxt_st.sd_m    = sample_in;
		nxt_st.sd_s    = st_ff.sd_m;
		nxt_st.sync_q  = sync_lvl;

		// Single mode flag from the three-level strap
		nxt_st.ext = ~strap_def;
		if (nxt_st.ext != st_ff.ext)
			ev[acc_pkg::INT_MODE] = 1'b1;

		// Range source follows the registered flag
		if (st_ff.ext)
			nxt_st.fs_code = st_ff.fsadj[7:0];
		else if (st_ff.strap_s == acc_pkg::STRAP_HIGH)
			nxt_st.fs_code = acc_pkg::FS_CODE_HIGH;
		else
			nxt_st.fs_code = acc_pkg::FS_CODE_LOW;

		// APB register writes
		if (wr_en && idx == acc_pkg::CFG_IDX)
			nxt_st.cfg = pwdata[15:0];
		if (wr_en && idx == acc_pkg::FSADJ_IDX)
			nxt_st.fsadj = pwdata[15:0];
		if (wr_en && idx == acc_pkg::IMASK_IDX)
			nxt_st.imask = pwdata[acc_pkg::INT_W-1:0];

		// Serial shifter; serial writes win over APB in the same cycle
		if (st_ff.ext && !cs_n) begin
			if (st_ff.sclk_s && !st_ff.sclk_q &&
			    st_ff.bitcnt != acc_pkg::SER_FULL) begin
				nxt_st.shreg  = {st_ff.shreg[acc_pkg::SER_BITS-2:0],
				                 st_ff.sdi_s};
				nxt_st.bitcnt = st_ff.bitcnt + 5'h01;
			end
		end else begin
			// Only a complete frame is applied; short frames vanish
			if (st_ff.ext && st_ff.bitcnt == acc_pkg::SER_FULL) begin
				ev[acc_pkg::INT_FRAME] = 1'b1;
				if (st_ff.shreg[19:16] == acc_pkg::CFG_IDX[3:0])
					nxt_st.cfg = st_ff.shreg[15:0];
				if (st_ff.shreg[19:16] == acc_pkg::FSADJ_IDX[3:0])
					nxt_st.fsadj = st_ff.shreg[15:0];
			end
			nxt_st.bitcnt = 5'h00;
		end

		// Sample on either edge of the sample clock
		nxt_st.samp_stb = st_ff.sck_s ^ st_ff.sck_q;
		if (st_ff.sck_s ^ st_ff.sck_q)
			nxt_st.sample = st_ff.sd_s;
		if (sync_rise) begin
			nxt_st.phase = '0;
			ev[acc_pkg::INT_SYNC] = 1'b1;
		end else if (st_ff.sck_s ^ st_ff.sck_q) begin
			nxt_st.phase = st_ff.phase + 1'b1;
		end

		// Request pulse qualifier: low time then high time, each counted
		if (st_ff.req_s != st_ff.req_q) begin
			nxt_st.req_cnt    = '0;
			nxt_st.req_low_ok = st_ff.req_s &&
			    st_ff.req_cnt == acc_pkg::REQ_W'(acc_pkg::CAL_REQ_MIN - 1);
		end else if (trig) begin
			nxt_st.req_cnt    = '0;
			nxt_st.req_low_ok = 1'b0;
		end else if (st_ff.req_cnt !=
		             acc_pkg::REQ_W'(acc_pkg::CAL_REQ_MIN - 1)) begin
			nxt_st.req_cnt = st_ff.req_cnt + 1'b1;
		end

		// Calibration sequencer; a request during a run is dropped
		case (st_ff.cal)
			acc_pkg::CAL_WAIT: begin
				if (st_ff.cal_cnt >= wait_len) begin
					nxt_st.cal     = acc_pkg::CAL_RUN;
					nxt_st.cal_cnt = '0;
				end else begin
					nxt_st.cal_cnt = st_ff.cal_cnt + 1'b1;
				end
			end
			acc_pkg::CAL_RUN: begin
				if (st_ff.cal_cnt == acc_pkg::CNT_W'(CAL_RUNC - 1)) begin
					nxt_st.cal     = acc_pkg::CAL_IDLE;
					nxt_st.cal_cnt = '0;
					ev[acc_pkg::INT_CAL_DONE] = 1'b1;
				end else begin
					nxt_st.cal_cnt = st_ff.cal_cnt + 1'b1;
				end
			end
			acc_pkg::CAL_IDLE: begin
				if (trig) begin
					nxt_st.cal     = acc_pkg::CAL_RUN;
					nxt_st.cal_cnt = '0;
				end
			end
			default: begin
				nxt_st.cal     = acc_pkg::CAL_IDLE;
				nxt_st.cal_cnt = '0;
			end
		endcase

		// Sticky status: a new event beats a same-cycle clear
		nxt_st.istat = (st_ff.istat & ~clr) | ev;
	end

	// State register; clock enable low freezes everything
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff       <= '0;
			st_ff.cfg   <= acc_pkg::CFG_RST;
			st_ff.fsadj <= acc_pkg::FSADJ_RST;
			st_ff.cal   <= acc_pkg::CAL_WAIT;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign ext_ctrl_mode        = st_ff.ext;
	assign full_scale_code      = st_ff.fs_code;
	assign serial_chip_select_n = cs_n;
	assign cal_delay_long       = dly_long;
	assign calibration_active   = (st_ff.cal == acc_pkg::CAL_RUN);
	assign sample_out           = st_ff.sample;
	assign sample_valid         = st_ff.samp_stb;
	assign sample_phase         = st_ff.phase;
	assign irq                  = |(st_ff.istat & st_ff.imask);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_range_low: assert property (ce && !st_ff.ext &&
		st_ff.strap_s == acc_pkg::STRAP_LOW |=>
		full_scale_code == acc_pkg::FS_CODE_LOW)
		else $error("small range not selected");
	a_range_high: assert property (ce && !st_ff.ext &&
		st_ff.strap_s == acc_pkg::STRAP_HIGH |=>
		full_scale_code == acc_pkg::FS_CODE_HIGH)
		else $error("large range not selected");
	a_mode_decode: assert property (ce && strap_def |=>
		!ext_ctrl_mode) else $error("mode flag wrong");
	a_range_reg: assert property (ce && st_ff.ext |=>
		full_scale_code == $past(st_ff.fsadj[7:0]))
		else $error("range not from adjust register");
	a_cs_share: assert property (ext_ctrl_mode |->
		!cal_delay_long) else $error("delay not forced short");
	a_both_edges: assert property (ce &&
		(st_ff.sck_s ^ st_ff.sck_q) |=> sample_valid)
		else $error("sample edge missed");
	a_sync_diff: assert property (ce && st_ff.cfg[14] &&
		st_ff.rp_s && !st_ff.rn_s && !st_ff.sync_q |=>
		sample_phase == '0) else $error("diff sync ignored");
	a_sync_single: assert property (ce && !st_ff.cfg[14] &&
		st_ff.rs_s && !st_ff.sync_q |=> sample_phase == '0)
		else $error("single sync ignored");
	a_cal_hold: assert property ($rose(calibration_active) |->
		calibration_active [*8]) else $error("calibration cut short");
	a_cal_cmd: assert property (ce && trig &&
		st_ff.cal == acc_pkg::CAL_IDLE |=> calibration_active)
		else $error("requested calibration not started");
	a_serial_idle: assert property (ce && !st_ff.ext |=>
		st_ff.bitcnt == 5'h00) else $error("shift outside extended");

endmodule : acc_ctrl

// [dv/acc_host_model.sv]
// Purpose: Host side driver for the strap, serial, calibration and
//          sample clock pins
// Assumes: Every change lands by non-blocking assignment after a rise
// Notes:   Serial clock stands still outside frames

`timescale 1ns/1ps

module acc_host_model (
	input  wire logic core_clk,
	output logic [1:0] strap,
	output logic       shared,
	output logic       sclk,
	output logic       sdi,
	output logic       cal_req,
	output logic       smp_clk,
	output logic [7:0] smp_d,
	output logic       sync_p,
	output logic       sync_n,
	output logic       sync_s
);
	// Quiet levels: defined strap, sync pair negative, request high
	initial begin
		strap   = 2'h0;
		shared  = 1'b0;
		sclk    = 1'b0;
		sdi     = 1'b0;
		cal_req = 1'b1;
		smp_clk = 1'b0;
		smp_d   = 8'h00;
		sync_p  = 1'b0;
		sync_n  = 1'b1;
		sync_s  = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	// Code 01 is the floating strap that asks for serial control
	task automatic pins(input logic [1:0] s, input logic sh);
		strap  <= s;
		shared <= sh;
		cyc(8);
	endtask : pins

	// Three cycles per phase keeps the synchroniser ahead of the clock
	task automatic frame(input logic [19:0] w);
		shared <= 1'b0;
		cyc(3);
		for (int i = 19; i >= 0; i--) begin
			sdi  <= w[i];
			cyc(3);
			sclk <= 1'b1;
			cyc(3);
			sclk <= 1'b0;
			cyc(3);
		end
		shared <= 1'b1;
		sdi    <= ~w[0]; // Released line shows no stale bit
		cyc(6);
	endtask : frame

	task automatic cal_pulse(input int lo, input int hi);
		cal_req <= 1'b0;
		cyc(lo);
		cal_req <= 1'b1;
		cyc(hi);
	endtask : cal_pulse

	// Positive pulse on the pair, or a high on the single input
	task automatic sync(input logic diff);
		if (diff) begin
			sync_p <= 1'b1;
			sync_n <= 1'b0;
		end else
			sync_s <= 1'b1;
		cyc(4);
		sync_p <= 1'b0;
		sync_n <= 1'b1;
		sync_s <= 1'b0;
		cyc(6);
	endtask : sync

	task automatic edge_in(input logic [7:0] d);
		smp_d   <= d;
		cyc(1);
		smp_clk <= ~smp_clk;
		cyc(6);
	endtask : edge_in
endmodule : acc_host_model

// [dv/tb_adc_mode_and_calibration_control.sv]
// Purpose: Self-checking bench for the converter mode control block
// Assumes: Short calibration counts of 16, 64 and 16 cycles
// Notes:   Checks are made at rising edges, before their updates land

`timescale 1ns/1ps

module tb_adc_mode_and_calibration_control;
	localparam logic [7:0] A_CFG = {acc_pkg::CFG_IDX, 2'h0};
	localparam logic [7:0] A_FSA = {acc_pkg::FSADJ_IDX, 2'h0};
	localparam logic [7:0] A_IST = {acc_pkg::ISTAT_IDX, 2'h0};
	localparam logic [7:0] A_IMS = {acc_pkg::IMASK_IDX, 2'h0};
	localparam logic [7:0] A_STA = {acc_pkg::STAT_IDX, 2'h0};
	logic        core_clk;
	logic        arst_n;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  strap;
	logic        shared;
	logic        sclk;
	logic        sdi;
	logic        cal_req;
	logic        smp_clk;
	logic [7:0]  smp_d;
	logic        sync_p;
	logic        sync_n;
	logic        sync_s;
	logic        ext_ctrl_mode;
	logic [7:0]  full_scale_code;
	logic        serial_chip_select_n;
	logic        cal_delay_long;
	logic        calibration_active;
	logic [7:0]  sample_out;
	logic        sample_valid;
	logic [7:0]  sample_phase;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          failures = 0;
	int          n_tests  = 0;
	int          cycles   = 0;
	int          n_valid  = 0;
	int          n;

	acc_ctrl #(.CAL_SHORT(16), .CAL_LONG(64), .CAL_RUNC(16)) u_dut (
		.core_clk(core_clk), .arst_n(arst_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .range_or_ext_ctrl_strap(strap),
		.cal_start_delay_select(shared), .serial_clk(sclk),
		.serial_input_line(sdi), .cal_request(cal_req),
		.sample_clk(smp_clk), .sample_in(smp_d),
		.sample_clock_sync_pos(sync_p), .sample_clock_sync_neg(sync_n),
		.sample_clock_sync_single(sync_s), .ext_ctrl_mode(ext_ctrl_mode),
		.full_scale_code(full_scale_code),
		.serial_chip_select_n(serial_chip_select_n),
		.cal_delay_long(cal_delay_long),
		.calibration_active(calibration_active),
		.sample_out(sample_out), .sample_valid(sample_valid),
		.sample_phase(sample_phase), .irq(irq));

	acc_host_model u_host (
		.core_clk(core_clk), .strap(strap), .shared(shared),
		.sclk(sclk), .sdi(sdi), .cal_req(cal_req), .smp_clk(smp_clk),
		.smp_d(smp_d), .sync_p(sync_p), .sync_n(sync_n),
		.sync_s(sync_s));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Counts capture pulses and cuts a hung run short
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (sample_valid === 1'b1)
			n_valid <= n_valid + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; only the run timeout ends the wait for pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	// Waits for a run to start, then measures how long it stays high
	task automatic cal_run(input int lo, input int lim);
		n = 0;
		while (calibration_active !== 1'b1 && n < lim) begin
			n++;
			@(posedge core_clk);
		end
		chk(n >= lo && n < lim, 1'b1);
		n = 0;
		while (calibration_active === 1'b1 && n < 100) begin
			n++;
			@(posedge core_clk);
		end
		chk(n, 16);
	endtask : cal_run

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	initial begin
		arst_n  = 1'b0;
		ce      = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		// Power-up wait with the short delay, then the run
		cal_run(16, 24);
		apb(0, A_CFG, 0);
		chk(rd, 32'h0);
		apb(0, A_FSA, 0);
		chk(rd, 32'h80);
		// Clock enable low freezes state, so the write is lost
		ce <= 1'b0;
		apb(1, A_FSA, 32'h55);
		ce <= 1'b1;
		apb(0, A_FSA, 0);
		chk(rd, 32'h80);
		apb(0, 8'h3c, 0);
		chk({err, rd[30:0]}, 32'h80000000);
		chk(full_scale_code, 8'h00);
		u_host.pins(2'h0, 1'b1);
		chk(cal_delay_long, 1'b1);
		u_host.pins(2'h3, 1'b0);
		chk(full_scale_code, 8'hff);
		// Sticky done bit raises irq only once unmasked
		apb(0, A_IST, 0);
		chk(rd, 32'h1);
		chk(irq, 1'b0);
		apb(1, A_IMS, 32'h1);
		chk(irq, 1'b1);
		apb(1, A_IST, 32'h1);
		chk(irq, 1'b0);
		// Low one cycle short: no start; full low, short high: not yet
		u_host.cal_pulse(79, 90);
		chk(calibration_active, 1'b0);
		u_host.cal_pulse(80, 70);
		chk(calibration_active, 1'b0);
		cal_run(0, 30);
		chk(irq, 1'b1);
		// Single-ended sync selected out of reset
		u_host.edge_in(8'h5a);
		chk(sample_out, 8'h5a);
		u_host.edge_in(8'ha5);
		chk({sample_out, sample_phase}, 16'ha502);
		chk(n_valid, 2);
		u_host.sync(1'b1);
		chk(sample_phase, 8'h02);
		u_host.sync(1'b0);
		chk(sample_phase, 8'h00);
		// Floating strap hands the pins to the serial port
		u_host.pins(2'h1, 1'b1);
		chk({ext_ctrl_mode, cal_delay_long}, 2'b10);
		chk({serial_chip_select_n, full_scale_code}, 9'h180);
		u_host.pins(2'h1, 1'b0);
		chk(serial_chip_select_n, 1'b0);
		u_host.pins(2'h1, 1'b1);
		u_host.frame({4'h3, 16'h0042});
		chk(full_scale_code, 8'h42);
		u_host.frame({4'h1, 16'h4000});
		apb(0, A_CFG, 0);
		chk(rd, 32'h4000);
		u_host.sync(1'b1);
		chk(sample_phase, 8'h00);
		u_host.edge_in(8'h11);
		u_host.sync(1'b0);
		chk(sample_phase, 8'h01);
		// Status: extended, idle, small range code, short delay, phase 1
		apb(0, A_STA, 0);
		chk(rd, 32'h101);
		// Done, sync, frame and mode change all seen by now
		apb(0, A_IST, 0);
		chk(rd, 32'hf);
		// Second reset with the long delay chosen on the shared pin
		u_host.pins(2'h0, 1'b1);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		cal_run(64, 72);
		print_verdict();
	end
endmodule : tb_adc_mode_and_calibration_control
